// ===== shared/pmbta_cfg.svh
/*
 * constants of the program memory byte table access block.
 * assumes inclusion by bare name from the package and design files.
 */
`ifndef PMBTA_CFG_SVH
`define PMBTA_CFG_SVH

`define PMBTA_WORD_W     16
`define PMBTA_BYTE_W     8
`define PMBTA_ADDR_W     15
`define PMBTA_HOLD_DEPTH 32
`define PMBTA_LATCH_RST  8'h00
`define PMBTA_HOLD_RST   8'h00
`define PMBTA_FETCH_CYC  1

`endif

// ===== shared/pmbta_pkg.sv
/*
 * types of the program memory byte table access block.
 * assumes pmbta_cfg.svh is on the include path.
 */
`include "pmbta_cfg.svh"

package pmbta_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_WAIT
  } pmbta_state_t;
endpackage

// ===== hw/pmbta_hold_buf.sv
/*
 * write-block holding registers, byte addressed, written by table writes.
 * assumes a single clock, synchronous active-low reset, enable freezes.
 */
`timescale 1ns/10ps
`include "pmbta_cfg.svh"

module pmbta_hold_buf #(
  parameter int DEPTH = `PMBTA_HOLD_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     clkEn,
  // byte write
  input  wire logic                     wrEn,
  input  wire logic [AW-1:0]            wrIdx,
  input  wire logic [`PMBTA_BYTE_W-1:0] wrByte,
  // commit-side read
  input  wire logic [AW-1:0]            rdIdx,
  output logic      [`PMBTA_BYTE_W-1:0] rdByte
);

  logic [`PMBTA_BYTE_W-1:0] holdMem_q [DEPTH];

  initial begin
    if (DEPTH < 2 || (DEPTH % 2) != 0)
      $error("holding depth must be even and at least 2");
  end

  // ==========================================================
  // storage
  for (genvar i = 0; i < DEPTH; i++) begin : g_hold
    always_ff @(posedge clk_sys) begin
      if (!reset_n)
        holdMem_q[i] <= `PMBTA_HOLD_RST;
      else if (clkEn && wrEn && wrIdx == AW'(i))
        holdMem_q[i] <= wrByte;
    end
  end

  assign rdByte = holdMem_q[rdIdx];

endmodule

// ===== hw/pmbta_table_access.sv
/*
 * byte-wide table read and write path between 16-bit program memory
 * and 8-bit data space, through one byte latch.
 * assumes core gives the byte address; commit sequence reads holdRdByte.
 */
`timescale 1ns/10ps
`include "pmbta_cfg.svh"

module pmbta_table_access #(
  parameter int ADDR_W     = `PMBTA_ADDR_W,
  parameter int HOLD_DEPTH = `PMBTA_HOLD_DEPTH,
  parameter int HOLD_AW    = $clog2(HOLD_DEPTH)
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     clkEn,
  // core requests
  input  wire logic                     program_memory_byte_read,
  input  wire logic                     program_memory_byte_write,
  input  wire logic [ADDR_W:0]          byteAddr,
  input  wire logic                     latchWrEn,
  input  wire logic [`PMBTA_BYTE_W-1:0] latchWrData,
  // program memory port
  output logic                          memRdEn,
  output logic      [ADDR_W-1:0]        memWordAddr,
  input  wire logic [`PMBTA_WORD_W-1:0] memRdWord,
  // results
  output logic      [`PMBTA_BYTE_W-1:0] table_byte_latch,
  output logic                          busy,
  output logic                          readDone,
  output logic                          writeDone,
  // holding register read for the commit sequence
  input  wire logic [HOLD_AW-1:0]       holdRdIdx,
  output logic      [`PMBTA_BYTE_W-1:0] holdRdByte
);

  initial begin
    if (ADDR_W < 1 || HOLD_DEPTH < 2 || HOLD_DEPTH % 2 != 0)
      $error("unsupported table access parameters");
    if (HOLD_AW != $clog2(HOLD_DEPTH) || HOLD_AW > ADDR_W + 1)
      $error("holding index does not fit the byte address");
  end

  // ==========================================================
  // state
  pmbta_pkg::pmbta_state_t   state_q, state_d;
  logic [`PMBTA_BYTE_W-1:0]  latch_q, latch_d;
  logic                      hiSel_q;
  logic [ADDR_W-1:0]         wordAddr_q;
  logic                      memRdEn_q, readDone_q, writeDone_q;
  logic                      busy_q;

  // ==========================================================
  // decode
  function automatic logic [`PMBTA_BYTE_W-1:0] pick_byte(
    input logic [`PMBTA_WORD_W-1:0] word,
    input logic                     hi
  );
    pick_byte = hi ? word[`PMBTA_WORD_W-1:`PMBTA_BYTE_W]
                   : word[`PMBTA_BYTE_W-1:0];
  endfunction

  wire idle      = (state_q == pmbta_pkg::ST_IDLE);
  wire startRd   = idle && program_memory_byte_read;
  // write only when no read pending; read wins a tie
  wire startWr   = idle && !program_memory_byte_read
                   && program_memory_byte_write;
  wire [`PMBTA_BYTE_W-1:0] fetchVal = pick_byte(memRdWord, hiSel_q);
  // any byte address is legal, lsb is the lane select
  wire [ADDR_W-1:0] reqWord = byteAddr[ADDR_W:1];
  wire              reqHi   = byteAddr[0];
  wire [HOLD_AW-1:0] holdIdx = byteAddr[HOLD_AW-1:0];

  always_comb begin
    state_d = state_q;
    latch_d = latch_q;
    unique case (state_q)
      pmbta_pkg::ST_IDLE: begin
        if (startRd)
          state_d = pmbta_pkg::ST_FETCH;
        else if (latchWrEn)
          latch_d = latchWrData;
      end
      pmbta_pkg::ST_FETCH: begin
        state_d = pmbta_pkg::ST_WAIT;
      end
      pmbta_pkg::ST_WAIT: begin
        latch_d = fetchVal;
        state_d = pmbta_pkg::ST_IDLE;
      end
      default: begin
        state_d = pmbta_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q     <= pmbta_pkg::ST_IDLE;
      latch_q     <= `PMBTA_LATCH_RST;
      hiSel_q     <= 1'b0;
      wordAddr_q  <= '0;
      memRdEn_q   <= 1'b0;
      readDone_q  <= 1'b0;
      writeDone_q <= 1'b0;
      busy_q      <= 1'b0;
    end else if (clkEn) begin
      state_q     <= state_d;
      latch_q     <= latch_d;
      memRdEn_q   <= startRd;
      readDone_q  <= (state_q == pmbta_pkg::ST_WAIT);
      writeDone_q <= startWr;
      busy_q      <= (state_d != pmbta_pkg::ST_IDLE);
      if (startRd) begin
        wordAddr_q <= reqWord;
        hiSel_q    <= reqHi;
      end
    end
  end

  // holding register write from the latch, never touches memory
  pmbta_hold_buf #(
    .DEPTH (HOLD_DEPTH),
    .AW    (HOLD_AW)
  ) u_hold (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clkEn   (clkEn),
    .wrEn    (startWr),
    .wrIdx   (holdIdx),
    .wrByte  (latch_q),
    .rdIdx   (holdRdIdx),
    .rdByte  (holdRdByte)
  );

  assign memRdEn          = memRdEn_q;
  assign memWordAddr      = wordAddr_q;
  assign table_byte_latch = latch_q;
  assign busy             = busy_q;
  assign readDone         = readDone_q;
  assign writeDone        = writeDone_q;

  // ==========================================================
  // checks
  a_read_fetch_seq: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (startRd && clkEn) ##1 clkEn [*2] |=> readDone
  ) else $error("table read did not complete in two cycles");

  a_read_lane_pick: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEn && state_q == pmbta_pkg::ST_WAIT) |=>
      latch_q == ($past(hiSel_q)
                  ? $past(memRdWord[`PMBTA_WORD_W-1:`PMBTA_BYTE_W])
                  : $past(memRdWord[`PMBTA_BYTE_W-1:0]))
  ) else $error("latch not loaded with selected byte");

  a_write_no_latch: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEn && startWr && !latchWrEn) |=> $stable(latch_q)
  ) else $error("table write altered the latch");

  a_word_addr_map: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEn && startRd) |=> memWordAddr == $past(byteAddr[ADDR_W:1])
      && memRdEn
  ) else $error("word address not taken from byte address");

  a_busy_no_mem: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    memRdEn |-> busy
  ) else $error("memory read outside a table read");

  // ==========================================================
  // read path checks
  a_mem_strobe_pulse: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEn && memRdEn) |=> !memRdEn
  ) else $error("memory read strobe longer than one cycle");
  a_fetch_to_wait: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEn && state_q == pmbta_pkg::ST_FETCH) |=>
      state_q == pmbta_pkg::ST_WAIT
  ) else $error("fetch not followed by wait");
  a_read_done_pulse: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEn && readDone) |=> !readDone
  ) else $error("read done longer than one cycle");
  a_busy_after_take: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEn && startRd) |=> busy
  ) else $error("busy not raised by a taken read");

  // ==========================================================
  // latch, write and freeze checks
  a_latch_only_src: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEn && !latchWrEn && state_q != pmbta_pkg::ST_WAIT) |=>
      $stable(latch_q)
  ) else $error("latch changed without a source");
  a_latch_wr_load: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEn && idle && latchWrEn && !program_memory_byte_read) |=>
      latch_q == $past(latchWrData)
  ) else $error("latch write not loaded");
  a_write_done_set: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEn && startWr) |=> writeDone && !memRdEn
  ) else $error("table write did not finish cleanly");
  a_write_refused: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEn && !idle) |=> !writeDone
  ) else $error("table write taken while busy");
  a_read_wins_tie: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEn && idle && program_memory_byte_read
      && program_memory_byte_write) |=> busy && !writeDone
  ) else $error("write taken against a read");
  a_freeze_all: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    !clkEn |=> $stable(state_q) && $stable(latch_q)
      && $stable(memRdEn) && $stable(readDone) && $stable(writeDone)
  ) else $error("state moved while clock enable low");

endmodule

// ===== bench/pmbta_mem_model.sv
/*
 * program memory model: a word answers a read strobe on the next cycle.
 * assumes memRdEn is a one-cycle strobe from the table access block.
 */
`timescale 1ns/10ps
module pmbta_mem_model (
  // clock
  input  wire logic        clk_sys,
  // memory port
  input  wire logic        memRdEn,
  input  wire logic [14:0] memWordAddr,
  output logic      [15:0] memRdWord = 16'h5A5A
);
  // =====================================================
  // word per address, inverted filler outside the slot
  always @(posedge clk_sys) begin
    if (memRdEn) begin
      memRdWord <= {memWordAddr[7:0] ^ 8'hC3, memWordAddr[7:0]};
    end else begin
      memRdWord <= ~memRdWord;
    end
  end
endmodule

// ===== bench/testbench.sv
/*
 * self-checking bench of the table access block with a memory model.
 * assumes the design files and pmbta_mem_model are compiled first.
 */
`timescale 1ns/10ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        clkEn = 1'b1;
  logic        rdReq = 1'b0;
  logic        wrReq = 1'b0;
  logic [15:0] byteAddr = 16'h0000;
  logic        latchWrEn = 1'b0;
  logic [7:0]  latchWrData = 8'h00;
  logic [4:0]  holdRdIdx = 5'h00;
  logic        memRdEn, busy, readDone, writeDone;
  logic [14:0] memWordAddr;
  logic [15:0] memRdWord;
  logic [7:0]  latchQ, holdRdByte;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cycCnt = 0;
  always #5 clk_sys = ~clk_sys;
  // =====================================================
  // instances
  pmbta_table_access dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .clkEn(clkEn), .program_memory_byte_read(rdReq),
    .program_memory_byte_write(wrReq), .byteAddr(byteAddr),
    .latchWrEn(latchWrEn), .latchWrData(latchWrData),
    .memRdEn(memRdEn), .memWordAddr(memWordAddr), .memRdWord(memRdWord),
    .table_byte_latch(latchQ), .busy(busy), .readDone(readDone),
    .writeDone(writeDone), .holdRdIdx(holdRdIdx), .holdRdByte(holdRdByte));
  pmbta_mem_model mem (.clk_sys(clk_sys), .memRdEn(memRdEn),
    .memWordAddr(memWordAddr), .memRdWord(memRdWord));
  // =====================================================
  // checking and closing
  task automatic cmpVal(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycCnt++;
    if (cycCnt == 2000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // =====================================================
  // transfers; intrude pushes refused requests while busy
  task automatic tableRead(logic [15:0] a, bit intrude);
    int n;
    logic [7:0] expB;
    expB = a[0] ? a[8:1] ^ 8'hC3 : a[8:1];
    @(negedge clk_sys);
    rdReq = 1'b1;
    wrReq = intrude;
    latchWrEn = intrude;
    latchWrData = 8'hEE;
    byteAddr = a;
    @(negedge clk_sys);
    rdReq = 1'b0;
    cmpVal("memRdEn", 16'h1, {15'h0, memRdEn});
    cmpVal("busy", 16'h1, {15'h0, busy});
    cmpVal("tieWriteDone", 16'h0, {15'h0, writeDone});
    cmpVal("memWordAddr", {1'b0, a[15:1]}, {1'b0, memWordAddr});
    n = 0;
    while (readDone !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    wrReq = 1'b0;
    latchWrEn = 1'b0;
    cmpVal("readLatency", 16'h2, n[15:0]);
    cmpVal("latch", {8'h0, expB}, {8'h0, latchQ});
    @(negedge clk_sys);
    cmpVal("writeDone", 16'h0, {15'h0, writeDone});
  endtask
  task automatic tableWrite(logic [15:0] a, logic [7:0] d);
    @(negedge clk_sys);
    latchWrEn = 1'b1;
    latchWrData = d;
    @(negedge clk_sys);
    latchWrEn = 1'b0;
    wrReq = 1'b1;
    byteAddr = a;
    holdRdIdx = a[4:0];
    @(negedge clk_sys);
    wrReq = 1'b0;
    cmpVal("writeDone", 16'h1, {15'h0, writeDone});
    cmpVal("holdByte", {8'h0, d}, {8'h0, holdRdByte});
    cmpVal("memRdEn", 16'h0, {15'h0, memRdEn});
  endtask
  // =====================================================
  // scenarios
  task automatic testReset();
    cmpVal("latchReset", 16'h0, {8'h0, latchQ});
    cmpVal("busyReset", 16'h0, {15'h0, busy});
    $display("test reset done");
  endtask
  task automatic testReads();
    logic [15:0] addrs [5] = '{16'h0000, 16'h0001, 16'h0123, 16'h0124,
                               16'hFFFF};
    foreach (addrs[i]) tableRead(addrs[i], 1'b0);
    $display("test reads done");
  endtask
  task automatic testWrites();
    tableWrite(16'h0013, 8'h5A);
    tableWrite(16'h0014, 8'hA5);
    tableWrite(16'h0008, 8'h3C);
    tableWrite(16'h0009, 8'hC3);
    holdRdIdx = 5'h13;
    #1 cmpVal("holdKeep", 16'h005A, {8'h0, holdRdByte});
    holdRdIdx = 5'h08;
    #1 cmpVal("instrLow", 16'h003C, {8'h0, holdRdByte});
    $display("test writes done");
  endtask
  task automatic testRefuse();
    tableRead(16'h0042, 1'b1);
    $display("test refuse done");
  endtask
  task automatic testFreeze();
    @(negedge clk_sys);
    clkEn = 1'b0;
    rdReq = 1'b1;
    byteAddr = 16'h0031;
    @(negedge clk_sys);
    cmpVal("frozenIdle", 16'h0, {15'h0, busy});
    clkEn = 1'b1;
    @(negedge clk_sys);
    rdReq = 1'b0;
    clkEn = 1'b0;
    repeat (2) @(negedge clk_sys);
    cmpVal("frozenStrobe", 16'h1, {15'h0, memRdEn});
    clkEn = 1'b1;
    repeat (2) @(negedge clk_sys);
    cmpVal("frozenDone", 16'h1, {15'h0, readDone});
    cmpVal("frozenLatch", 16'h00DB, {8'h0, latchQ});
    $display("test freeze done");
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    testReset();
    testReads();
    testWrites();
    testRefuse();
    testFreeze();
    end_of_test();
  end
endmodule
